//--- include/rpc_defines.vh
// Operation
// R01 - Proprietary fieldbus runs 187500 or 400000 baud, 187500 by default.
// R02 - Modbus rates 9600 to 256000 baud, default 19200.
// R03 - Modbus framing RTU or ASCII, chosen by configuration.
// R04 - Modbus slave only; answers only what the master started.
// R05 - Modbus slave address configurable up to 247.
// R06 - Proprietary fieldbus holds up to 120 nodes with distinct addresses.
// R07 - Join automatic node search and gap-closing address optimisation.
// R08 - Top connector address is ten times tens digit plus units digit.
// R09 - Switches at 00 select automatic address installation.
// R10 - Top connector rate and parity only from written parameters.
// R11 - Push switch held from power-up: after hold, flash LEDs; release toggles mode.
// R12 - Configuration mode forces side port to RS232 at 38400 baud.
// R13 - Configuration mode state survives power loss.
// R14 - Same sequence in configuration mode leaves it, restoring stored settings.
// R15 - Side port set for RS485 ignores RS232 unless configuration mode.
// R16 - Side address and rate always writable; other side settings only in config mode.
// R17 - Factory reset leaves stored communication settings untouched.
// R18 - Local host relays RS232 requests onto the proprietary fieldbus.
// R19 - Switches sampled once after reset release, kept until next power-up.
`ifndef RPC_DEFINES_VH
`define RPC_DEFINES_VH

// Register byte offsets
`define RPC_OFS_CTRL    8'h00
`define RPC_OFS_ADDR    8'h04
`define RPC_OFS_STATUS  8'h08

// Control field positions
`define RPC_CTRL_PROTO  0
`define RPC_CTRL_ASCII  1
`define RPC_CTRL_FAST   2
`define RPC_CTRL_RATE_L 3
`define RPC_CTRL_RATE_H 5
`define RPC_CTRL_PAR_L  6
`define RPC_CTRL_PAR_H  7
`define RPC_CTRL_SIDE   8
`define RPC_CTRL_LHOST  9
`define RPC_CTRL_WMASK  32'h0000_003c
`define RPC_CTRL_RESET  10'h08b

// Address limits and defaults
`define RPC_ADDR_RESET  8'h03
`define RPC_ADDR_MIN    8'h01
`define RPC_ADDR_MB_MAX 8'hf7
`define RPC_ADDR_FB_MAX 8'h78

// Line rates in baud
`define RPC_BAUD_FB_LO  19'd187500
`define RPC_BAUD_FB_HI  19'd400000
`define RPC_BAUD_CFG    19'd38400

// Side port protocol codes
`define RPC_SIDE_RS232  2'h0
`define RPC_SIDE_FB485  2'h1
`define RPC_SIDE_MBRTU  2'h2
`define RPC_SIDE_MBASC  2'h3

// Hold and flash times
`define RPC_HOLD_MS     12000
`define RPC_FLASH_MS    200
`define RPC_CLK_KHZ     100000

`endif

//--- verilog/rpc_port_config.v
`timescale 1ns/10ps
`default_nettype none
`include "rpc_defines.vh"

module rpc_port_config #(
    parameter HOLD_CYC  = `RPC_HOLD_MS * `RPC_CLK_KHZ,
    parameter FLASH_CYC = `RPC_FLASH_MS * `RPC_CLK_KHZ
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Panel pins
    input  wire [3:0]  tens_digit_switch,
    input  wire [3:0]  units_digit_switch,
    input  wire        push_switch,
    input  wire        top_conn_present,
    output reg         led_green,
    output reg         led_red,
    // Nonvolatile store of the configuration mode flag
    input  wire        nv_cfg_mode,
    output reg         nv_cfg_wr,
    output reg         nv_cfg_data,
    // Fieldbus engine
    input  wire        search_addr_valid,
    input  wire [7:0]  search_addr,
    input  wire        rs232_req,
    input  wire        factory_reset,
    output reg         relay_req,
    // Modbus engine
    input  wire        mb_request,
    input  wire        mb_reply_done,
    output reg         mb_reply_permit,
    // Port settings
    output reg  [1:0]  side_proto,
    output reg  [18:0] side_baud,
    output reg  [1:0]  side_parity,
    output reg         side_rs232_en,
    output reg  [18:0] top_baud,
    output reg  [1:0]  top_parity,
    output reg         top_ascii,
    output reg  [7:0]  node_addr,
    output reg         auto_install
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg  [9:0] pin_s1_reg;
reg  [9:0] pin_s2_reg;

// Two stages before any logic reads a pin
always @(posedge clk) begin
    if (!rstn) begin
        pin_s1_reg <= 10'h000;
        pin_s2_reg <= 10'h000;
    end else begin
        pin_s1_reg <= {top_conn_present, push_switch,
                       tens_digit_switch, units_digit_switch};
        pin_s2_reg <= pin_s1_reg;
    end
end

wire       push_s = pin_s2_reg[8];
wire       top_s  = pin_s2_reg[9];

////////////////////////////////////////////////////////////////////////////////
// Power-up capture and hold sequence

localparam ST_WAIT  = 3'h0;
localparam ST_SAMP  = 3'h1;
localparam ST_HOLD  = 3'h2;
localparam ST_FLASH = 3'h3;
localparam ST_RUN   = 3'h4;
localparam ST_WAIT2 = 3'h5;

reg  [2:0]  st_reg;
reg  [2:0]  st_next;
reg  [31:0] cnt_reg;
reg  [31:0] fcnt_reg;
reg  [3:0]  tens_reg;
reg  [3:0]  units_reg;
reg         top_reg;
reg         cfg_mode_reg;
reg         flash_reg;
reg         toggle;

// Next state of the sequence
always @* begin
    st_next = st_reg;
    toggle  = 1'b0;
    case (st_reg)
        // Two waits so the second synchroniser stage holds the pins
        ST_WAIT:  st_next = ST_WAIT2;
        ST_WAIT2: st_next = ST_SAMP;              //R19
        ST_SAMP:  st_next = push_s ? ST_HOLD : ST_RUN;
        ST_HOLD: begin
            if (!push_s)
                st_next = ST_RUN;                 // Released too early
            else if (cnt_reg >= HOLD_CYC - 1)
                st_next = ST_FLASH;               //R11
        end
        ST_FLASH: begin
            if (!push_s) begin
                st_next = ST_RUN;
                toggle  = 1'b1;                   //R11 R14
            end
        end
        ST_RUN:   st_next = ST_RUN;
        default:  st_next = ST_WAIT;
    endcase
end

// Two wait states let the synchronisers fill before the one-time sample
always @(posedge clk) begin
    if (!rstn) begin
        st_reg       <= ST_WAIT;
        cnt_reg      <= 32'h0000_0000;
        fcnt_reg     <= 32'h0000_0000;
        flash_reg    <= 1'b0;
        tens_reg     <= 4'h0;
        units_reg    <= 4'h0;
        top_reg      <= 1'b0;
        cfg_mode_reg <= 1'b0;
        nv_cfg_wr    <= 1'b0;
        nv_cfg_data  <= 1'b0;
    end else begin
        st_reg    <= st_next;
        nv_cfg_wr <= toggle;
        if (st_reg == ST_SAMP) begin
            tens_reg     <= pin_s2_reg[7:4];     //R19
            units_reg    <= pin_s2_reg[3:0];     //R19
            top_reg      <= top_s;               //R19
            cfg_mode_reg <= nv_cfg_mode;         //R13
            nv_cfg_data  <= nv_cfg_mode;
        end
        if (toggle) begin
            cfg_mode_reg <= ~cfg_mode_reg;       //R11 R14
            nv_cfg_data  <= ~cfg_mode_reg;       //R13
        end
        cnt_reg <= (st_reg == ST_HOLD) ? cnt_reg + 32'h0000_0001
                                       : 32'h0000_0000;
        // Equal on and off times while waiting for release
        if (st_reg != ST_FLASH) begin
            fcnt_reg  <= 32'h0000_0000;
            flash_reg <= 1'b0;
        end else if (fcnt_reg >= FLASH_CYC - 1) begin
            fcnt_reg  <= 32'h0000_0000;
            flash_reg <= ~flash_reg;             //R11
        end else begin
            fcnt_reg  <= fcnt_reg + 32'h0000_0001;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Switch address

// Decimal digits above 9 are not valid; they clamp to 9
wire [3:0] tens_c  = (tens_reg > 4'h9) ? 4'h9 : tens_reg;
wire [3:0] units_c = (units_reg > 4'h9) ? 4'h9 : units_reg;
wire [7:0] sw_addr = {tens_c, 3'b000} + {3'b000, tens_c, 1'b0}
                   + {4'h0, units_c};                 //R08
wire       sw_zero = (sw_addr == 8'h00);              //R09

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [9:0] ctrl_reg;
reg  [7:0] addr_reg;
reg  [7:0] search_reg;

wire       mb_mode  = ctrl_reg[`RPC_CTRL_PROTO];
wire       acc      = psel & penable & pready;
wire       wr_ctrl  = acc & pwrite & (paddr == `RPC_OFS_CTRL);
wire       wr_addr  = acc & pwrite & (paddr == `RPC_OFS_ADDR);
wire [7:0] addr_max = mb_mode ? `RPC_ADDR_MB_MAX : `RPC_ADDR_FB_MAX;
wire       addr_ok  = (pwdata[31:8] == 24'h000000)
                    & (pwdata[7:0] >= `RPC_ADDR_MIN)
                    & (pwdata[7:0] <= addr_max);      //R05 R06
wire       hit      = (paddr == `RPC_OFS_CTRL) | (paddr == `RPC_OFS_ADDR)
                    | (paddr == `RPC_OFS_STATUS);
wire       bad      = !hit | (pwrite & (paddr == `RPC_OFS_STATUS))
                    | (pwrite & (paddr == `RPC_OFS_ADDR) & !addr_ok);
wire [31:0] wmask   = cfg_mode_reg ? 32'h0000_03ff : `RPC_CTRL_WMASK;

// Outside configuration mode only the rate fields take a write;
// factory_reset is deliberately not a term here
always @(posedge clk) begin
    if (!rstn) begin
        ctrl_reg   <= `RPC_CTRL_RESET;          //R01 R02
        addr_reg   <= `RPC_ADDR_RESET;
        search_reg <= 8'h00;
    end else begin
        if (wr_ctrl)
            ctrl_reg <= (ctrl_reg & ~wmask[9:0])
                      | (pwdata[9:0] & wmask[9:0]);   //R16 R10 R03 R17
        if (wr_addr & addr_ok)
            addr_reg <= pwdata[7:0];                  //R16 R05
        if (search_addr_valid && search_addr >= `RPC_ADDR_MIN
                && search_addr <= `RPC_ADDR_FB_MAX)
            search_reg <= search_addr;                //R07
    end
end

////////////////////////////////////////////////////////////////////////////////
// APB answer, one wait state

always @(posedge clk) begin
    if (!rstn) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end else begin
        pready  <= psel & penable & !pready;
        pslverr <= psel & penable & !pready & bad;
        prdata  <= 32'h0000_0000;
        if (psel & penable & !pready & !pwrite) begin
            case (paddr)
                `RPC_OFS_CTRL:   prdata <= {22'h000000, ctrl_reg};
                `RPC_OFS_ADDR:   prdata <= {24'h000000, addr_reg};
                `RPC_OFS_STATUS: prdata <= {2'b00, top_baud, node_addr,
                                            st_reg == ST_FLASH, auto_install,
                                            cfg_mode_reg};
                default:         prdata <= 32'h0000_0000;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Rate tables

reg  [18:0] mb_baud;

// Eight Modbus rates, index 1 is the default
always @* begin
    case (ctrl_reg[`RPC_CTRL_RATE_H:`RPC_CTRL_RATE_L])     //R02
        3'h0:    mb_baud = 19'd9600;
        3'h1:    mb_baud = 19'd19200;
        3'h2:    mb_baud = 19'd38400;
        3'h3:    mb_baud = 19'd56000;
        3'h4:    mb_baud = 19'd57600;
        3'h5:    mb_baud = 19'd115200;
        3'h6:    mb_baud = 19'd128000;
        default: mb_baud = 19'd256000;
    endcase
end

wire [18:0] fb_baud = ctrl_reg[`RPC_CTRL_FAST] ? `RPC_BAUD_FB_HI
                                                : `RPC_BAUD_FB_LO; //R01
wire [18:0] bus_baud = mb_mode ? mb_baud : fb_baud;
wire [1:0]  bus_proto = !mb_mode ? `RPC_SIDE_FB485 :
                        ctrl_reg[`RPC_CTRL_ASCII] ? `RPC_SIDE_MBASC
                                                  : `RPC_SIDE_MBRTU; //R03
wire        side485 = ctrl_reg[`RPC_CTRL_SIDE];
wire [1:0]  parity  = mb_mode ? ctrl_reg[`RPC_CTRL_PAR_H:`RPC_CTRL_PAR_L]
                              : 2'h0;

////////////////////////////////////////////////////////////////////////////////
// Port settings and traffic permits

always @(posedge clk) begin
    if (!rstn) begin
        side_proto      <= `RPC_SIDE_RS232;
        side_baud       <= `RPC_BAUD_CFG;
        side_parity     <= 2'h0;
        side_rs232_en   <= 1'b0;
        top_baud        <= `RPC_BAUD_FB_LO;
        top_parity      <= 2'h0;
        top_ascii       <= 1'b0;
        node_addr       <= `RPC_ADDR_RESET;
        auto_install    <= 1'b0;
        led_green       <= 1'b0;
        led_red         <= 1'b0;
        relay_req       <= 1'b0;
        mb_reply_permit <= 1'b0;
    end else begin
        // Config mode overrides whatever bus type is stored
        if (cfg_mode_reg || !side485) begin
            side_proto  <= `RPC_SIDE_RS232;         //R12 R15
            side_baud   <= `RPC_BAUD_CFG;           //R12
            side_parity <= 2'h0;
        end else begin
            side_proto  <= bus_proto;               //R14 R15
            side_baud   <= bus_baud;
            side_parity <= parity;
        end
        side_rs232_en <= cfg_mode_reg | !side485;   //R15
        top_baud      <= bus_baud;                  //R10
        top_parity    <= parity;                    //R10
        top_ascii     <= ctrl_reg[`RPC_CTRL_ASCII]; //R03
        // Top connector takes the switches, side port its register
        if (top_reg) begin
            auto_install <= sw_zero;                //R09
            node_addr    <= sw_zero ? search_reg : sw_addr; //R08 R07
        end else begin
            auto_install <= 1'b0;
            node_addr    <= addr_reg;
        end
        led_green <= flash_reg;                     //R11
        led_red   <= flash_reg;                     //R11
        // Relay only on fieldbus with the side port on RS232
        relay_req <= rs232_req & ctrl_reg[`RPC_CTRL_LHOST]
                   & !mb_mode & top_reg & (cfg_mode_reg | !side485); //R18
        // Reply window opens on a master request only; a new request
        // in the closing cycle keeps it open
        if (!mb_mode)
            mb_reply_permit <= 1'b0;
        else if (mb_request)
            mb_reply_permit <= 1'b1;                //R04
        else if (mb_reply_done)
            mb_reply_permit <= 1'b0;                //R04
    end
end

endmodule
`default_nettype wire

//--- tb/rpc_port_config_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rpc_port_config_monitor #(
    parameter HOLD_CYC  = 20,
    parameter FLASH_CYC = 4
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Bus and engines
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        rs232_req,
    input wire logic        relay_req,
    input wire logic        mb_request,
    input wire logic        mb_reply_done,
    input wire logic        mb_reply_permit,
    // Panel and settings
    input wire logic        nv_cfg_wr,
    input wire logic        led_green,
    input wire logic        led_red,
    input wire logic [1:0]  side_proto,
    input wire logic        side_rs232_en,
    input wire logic [7:0]  node_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    ////////////////////////////////////////////////////////////////
    // One wait state, then a single answer cycle
    a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("late");
    a_ready_once: assert property (pready |=> !pready) else $error("long ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("stale rdata");
    // Relay only follows a host request
    a_relay_cause: assert property (relay_req |-> $past(rs232_req)) else $error("relay");
    // Answer window opened and closed by the master only, while in Modbus mode
    a_permit_open: assert property ($rose(mb_reply_permit) |-> $past(mb_request)) else $error("open");
    a_permit_close: assert property ($fell(mb_reply_permit) |-> $past(mb_reply_done)) else $error("close");
    a_store_pulse: assert property (nv_cfg_wr |=> !nv_cfg_wr) else $error("store");
    a_led_pair: assert property ($changed(led_green) |-> led_red == led_green) else $error("led");
    a_side_serial: assert property (side_rs232_en |-> side_proto == 2'h0) else $error("side");
    a_node_cap: assert property (node_addr <= 8'd120) else $error("node cap");
    // Main scenarios
    cover property (pslverr);
    cover property ($rose(mb_reply_permit));
    cover property (nv_cfg_wr);
    cover property (relay_req);
endmodule
bind rpc_port_config rpc_port_config_monitor #(
    .HOLD_CYC(HOLD_CYC),
    .FLASH_CYC(FLASH_CYC)
) i_rpc_port_config_monitor (.*);
`default_nettype wire

//--- tb/rpc_bus_master.sv
`timescale 1ns/10ps
`default_nettype none
module rpc_bus_master (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rstn,
    // Stimulus
    input wire logic       start,
    input wire logic [3:0] delay,
    // Slave side
    output var logic       mb_request,
    output var logic       mb_reply_done,
    input wire logic       mb_reply_permit
);
    logic       busy;
    logic [3:0] cnt;
    ////////////////////////////////////////////////////////////////
    // Master starts every exchange; reply ends after a chosen delay
    always @(posedge clk) begin
        mb_request <= 1'b0;
        mb_reply_done <= 1'b0;
        if (!rstn) begin
            busy <= 1'b0;
            cnt <= 4'h0;
        end else if (start && !busy) begin
            mb_request <= 1'b1;
            busy <= 1'b1;
            cnt <= delay;
        end else if (busy && mb_reply_permit) begin
            // Reply only inside the permit window
            if (cnt == 4'h0) begin
                mb_reply_done <= 1'b1;
                busy <= 1'b0;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rpc_defines.vh"
module tb;
    localparam HOLD = 20;
    localparam FLASH = 4;
    logic        clk, rstn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [7:0]  paddr, s_addr, node;
    logic [31:0] pwdata, prdata, rd_data;
    logic [3:0]  tens, units;
    logic        push, top, lg, lr, nv_mode, nv_wr, nv_data, s_valid, rs232_req, f_rst;
    logic        relay, mb_req, mb_done, permit, mb_start, s_en, t_ascii, auto;
    logic [1:0]  s_proto, s_par, t_par;
    logic [18:0] s_baud, t_baud;
    logic [18:0] mb_rate [8] = '{19'd9600, 19'd19200, 19'd38400, 19'd56000,
                                 19'd57600, 19'd115200, 19'd128000, 19'd256000};
    int          err_total, n_tests;
    rpc_port_config #(.HOLD_CYC(HOLD), .FLASH_CYC(FLASH)) i_rpc_port_config (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tens_digit_switch(tens), .units_digit_switch(units), .push_switch(push),
        .top_conn_present(top), .led_green(lg), .led_red(lr), .nv_cfg_mode(nv_mode),
        .nv_cfg_wr(nv_wr), .nv_cfg_data(nv_data), .search_addr_valid(s_valid),
        .search_addr(s_addr), .rs232_req(rs232_req), .factory_reset(f_rst),
        .relay_req(relay), .mb_request(mb_req), .mb_reply_done(mb_done),
        .mb_reply_permit(permit), .side_proto(s_proto), .side_baud(s_baud),
        .side_parity(s_par), .side_rs232_en(s_en), .top_baud(t_baud), .top_parity(t_par),
        .top_ascii(t_ascii), .node_addr(node), .auto_install(auto));
    rpc_bus_master i_rpc_bus_master (.clk(clk), .rstn(rstn), .start(mb_start),
        .delay(4'h4), .mb_request(mb_req), .mb_reply_done(mb_done), .mb_reply_permit(permit));
    ////////////////////////////////////////////////////////////////
    // Clock and nonvolatile flag store
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (nv_wr) nv_mode <= nv_data;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Setup, access, hold until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 0, 1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("rdata", rd_data, exp);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        chk("werr", rd_err, e);
    endtask
    task rst();
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
    endtask
    // Power up with the button held, watch the flash, release
    task toggle_cfg(input logic [31:0] ctl);
        logic led;
        push <= 1'b1;
        rst();
        repeat (HOLD + 10) @(posedge clk);
        @(negedge clk);
        led = lg;
        repeat (FLASH) @(negedge clk);
        chk("led", lg, !led);
        @(posedge clk);
        // Still in the old mode while held: settings written here stay
        if (ctl != 32'h0) wr(`RPC_OFS_CTRL, ctl, 1'b0);
        push <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    task test_done();
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        err_total++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////
    // Scenarios
    initial begin
        {rstn, psel, penable, pwrite, push, nv_mode, s_valid, rs232_req, f_rst, mb_start} = '0;
        {paddr, pwdata, s_addr} = '0;
        tens = 4'h4;
        units = 4'h2;
        top = 1'b1;
        err_total = 0;
        n_tests = 0;
        rst();
        chk("node", node, 42);
        chk("auto", auto, 0);
        tens <= 4'h9;
        rd(`RPC_OFS_CTRL, 32'h08b);
        rd(`RPC_OFS_ADDR, 32'h3);
        for (int i = 0; i < 8; i++) begin
            wr(`RPC_OFS_CTRL, i << 3, 1'b0);
            rd(`RPC_OFS_CTRL, 32'h083 | (i << 3));
            chk("rate", t_baud, mb_rate[i]);
        end
        chk("node_kept", node, 42);
        wr(`RPC_OFS_CTRL, 32'hffff_ffff, 1'b0);
        rd(`RPC_OFS_CTRL, 32'h0bf);
        wr(`RPC_OFS_CTRL, 32'h08b, 1'b0);
        wr(`RPC_OFS_ADDR, 32'd247, 1'b0);
        wr(`RPC_OFS_ADDR, 32'd248, 1'b1);
        wr(`RPC_OFS_ADDR, 32'd0, 1'b1);
        rd(`RPC_OFS_ADDR, 32'd247);
        wr(`RPC_OFS_STATUS, 32'h1, 1'b1);
        apb(1'b0, 8'h0c, 32'h0);
        chk("unmapped", rd_err, 1);
        f_rst <= 1'b1;
        @(posedge clk);
        f_rst <= 1'b0;
        rd(`RPC_OFS_CTRL, 32'h08b);
        mb_start <= 1'b1;
        @(posedge clk);
        mb_start <= 1'b0;
        repeat (2) @(posedge clk);
        chk("permit", permit, 1);
        repeat (10) @(posedge clk);
        chk("permit_end", permit, 0);
        toggle_cfg(32'h0);
        chk("stored", nv_mode, 1);
        chk("side_en", s_en, 1);
        chk("side_baud", s_baud, `RPC_BAUD_CFG);
        chk("side_proto", s_proto, `RPC_SIDE_RS232);
        apb(1'b0, `RPC_OFS_STATUS, 32'h0);
        chk("cfg", rd_data[0], 1);
        wr(`RPC_OFS_CTRL, 32'h304, 1'b0);
        rd(`RPC_OFS_CTRL, 32'h304);
        chk("fast", t_baud, `RPC_BAUD_FB_HI);
        wr(`RPC_OFS_CTRL, 32'h300, 1'b0);
        @(posedge clk);
        chk("slow", t_baud, `RPC_BAUD_FB_LO);
        wr(`RPC_OFS_ADDR, 32'd121, 1'b1);
        wr(`RPC_OFS_ADDR, 32'd120, 1'b0);
        rs232_req <= 1'b1;
        @(posedge clk);
        rs232_req <= 1'b0;
        #1 chk("relay", relay, 1);
        rst();
        chk("persist", s_en, 1);
        toggle_cfg(32'h304);
        chk("left", nv_mode, 0);
        chk("rs485", s_en, 0);
        chk("restored", s_proto, `RPC_SIDE_FB485);
        tens <= 4'h0;
        units <= 4'h0;
        rst();
        chk("auto00", auto, 1);
        s_addr <= 8'd17;
        s_valid <= 1'b1;
        @(posedge clk);
        s_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("search", node, 17);
        test_done();
    end
endmodule
`default_nettype wire
